/* src/apr_power_rate_ctl.sv */
// Power-mode and output-data-rate controller for a three-axis sensor core.
// Assumes synchronous register strobes and an external inactivity detector.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module apr_power_rate_ctl
    import apr_pkg::*;
#(
    parameter int unsigned BASE_CYCLES = TOP_SAMPLE_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    input wire logic inactivityDetected,
    input wire logic activityDetected,
    output logic [7:0] inactThreshold,
    output logic [7:0] inactTime,
    output logic measureActive,
    output logic sleepActive,
    output logic lowPowerActive,
    output logic [3:0] activeRate,
    output logic sampleStrobe,
    output logic bufferWrite
);

    // ------------------------------------------------------------------
    // State and helpers
    // ------------------------------------------------------------------
    apr_state_type s;
    apr_state_type next_s;
    logic [31:0] periodCycles;
    logic boundary;
    logic autoSleepOn;
    logic [7:0] statusByte;

    // Sample period grows by a factor of two for every step below the top code.
    assign periodCycles = BASE_CYCLES << (RATE_TOP - s.activeRate);

    // A boundary is a sample tick, or any cycle while nothing is sampling.
    assign boundary = s.sampleStrobe || (s.mode == MODE_STANDBY);

    // Autosleep needs both the sleep enable and the activity link.
    assign autoSleepOn = s.regs.powerCtl[AUTOSLEEP_BIT]
        && s.regs.powerCtl[LINK_BIT];

    // Status byte shows the live mode and the rate now in force.
    always_comb
    begin
        statusByte = 8'h00;
        statusByte[STAT_MEASURE_BIT] = (s.mode != MODE_STANDBY);
        statusByte[STAT_SLEEP_BIT] = (s.mode == MODE_SLEEP);
        statusByte[STAT_LOW_POWER_BIT] = s.activeLowPower;
        statusByte[STAT_RATE_LSB +: 4] = s.activeRate;
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Register writes are taken at any time, standby included.
    // Reads answer one cycle later; unmapped addresses read as zero.
    always_comb
    begin
        next_s = s;
        next_s.sampleStrobe = 1'b0;
        if (regWrite)
        begin
            case (regAddr)
                OFS_INACT_THRESH: next_s.regs.inactThresh = regWriteData;
                OFS_INACT_TIME: next_s.regs.inactTime = regWriteData;
                OFS_RATE_CTL: next_s.regs.rateCtl = regWriteData;
                OFS_POWER_MODE_CONTROL: next_s.regs.powerCtl = regWriteData;
                default: next_s.regs = s.regs;
            endcase
        end
        if (regRead)
        begin
            case (regAddr)
                OFS_INACT_THRESH: next_s.readData = s.regs.inactThresh;
                OFS_INACT_TIME: next_s.readData = s.regs.inactTime;
                OFS_RATE_CTL: next_s.readData = s.regs.rateCtl;
                OFS_POWER_MODE_CONTROL: next_s.readData = s.regs.powerCtl;
                OFS_MODE_STATUS: next_s.readData = statusByte;
                default: next_s.readData = 8'h00;
            endcase
        end

        // Sample timer runs only outside standby; standby holds it at zero.
        if (s.mode == MODE_STANDBY)
        begin
            next_s.sampleCount = 32'h0000_0000;
        end
        else if (s.sampleCount >= periodCycles - 32'h0000_0001)
        begin
            next_s.sampleCount = 32'h0000_0000;
            next_s.sampleStrobe = 1'b1;
        end
        else
        begin
            next_s.sampleCount = s.sampleCount + 32'h0000_0001;
        end

        // Mode and rate only move on a boundary.
        if (boundary)
        begin
            case (s.mode)
                MODE_STANDBY:
                begin
                    if (s.regs.powerCtl[MEASURE_BIT])
                    begin
                        next_s.mode = MODE_MEASURE;
                        next_s.sampleCount = 32'h0000_0000;
                    end
                end
                MODE_MEASURE:
                begin
                    if (!s.regs.powerCtl[MEASURE_BIT])
                    begin
                        next_s.mode = MODE_STANDBY;
                    end
                    else if (autoSleepOn && inactivityDetected)
                    begin
                        next_s.mode = MODE_SLEEP;
                    end
                end
                MODE_SLEEP:
                begin
                    if (!s.regs.powerCtl[MEASURE_BIT])
                    begin
                        next_s.mode = MODE_STANDBY;
                    end
                    else if (!autoSleepOn || activityDetected)
                    begin
                        next_s.mode = MODE_MEASURE;
                    end
                end
                default: next_s.mode = MODE_STANDBY;
            endcase

            // Sleep forces the slow rate; otherwise the written code applies.
            if (next_s.mode == MODE_SLEEP)
            begin
                next_s.activeRate = SLEEP_RATE;
                next_s.activeLowPower = 1'b0;
            end
            else
            begin
                next_s.activeRate = s.regs.rateCtl[RATE_LSB +: 4];
                next_s.activeLowPower = (next_s.mode == MODE_MEASURE)
                    && s.regs.rateCtl[LOW_POWER_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Power-up lands in standby with every control cleared.
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s.regs.inactThresh <= RST_REG;
            s.regs.inactTime <= RST_REG;
            s.regs.rateCtl <= RST_REG;
            s.regs.powerCtl <= RST_REG;
            s.mode <= MODE_STANDBY;
            s.activeRate <= 4'h0;
            s.activeLowPower <= 1'b0;
            s.sampleCount <= 32'h0000_0000;
            s.sampleStrobe <= 1'b0;
            s.readData <= 8'h00;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The buffer only takes samples while measuring; standby never clears it.
    assign regReadData = s.readData;
    assign inactThreshold = s.regs.inactThresh;
    assign inactTime = s.regs.inactTime;
    assign measureActive = (s.mode != MODE_STANDBY);
    assign sleepActive = (s.mode == MODE_SLEEP);
    assign lowPowerActive = s.activeLowPower;
    assign activeRate = s.activeRate;
    assign sampleStrobe = s.sampleStrobe;
    assign bufferWrite = s.sampleStrobe && (s.mode != MODE_STANDBY);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // Standby takes no samples.
    a_standby_no_sample: assert property (
        (s.mode == MODE_STANDBY) |=> !s.sampleStrobe)
        else $error("sample taken in standby");

    // A measure write in standby starts measuring two edges later.
    a_measure_entry: assert property (
        (regWrite && regAddr == OFS_POWER_MODE_CONTROL
            && regWriteData[MEASURE_BIT] && s.mode == MODE_STANDBY)
        |=> ##1 measureActive)
        else $error("measure bit did not start measurement");

    // A cleared measure bit ends measuring at the next sample tick.
    a_standby_entry: assert property (
        (s.mode != MODE_STANDBY && !s.regs.powerCtl[MEASURE_BIT]
            && s.sampleStrobe) |=> !measureActive)
        else $error("cleared measure bit did not reach standby");

    // Reads return the register value held at the read edge.
    a_read_back: assert property (
        (regRead && regAddr == OFS_RATE_CTL)
        |=> regReadData == $past(s.regs.rateCtl))
        else $error("rate register read back wrong");

    // Sleep always runs at the slow rate.
    a_sleep_rate: assert property (
        sleepActive |-> (activeRate == SLEEP_RATE && !lowPowerActive))
        else $error("sleep not at slow rate");

    // Inactivity with autosleep armed sends the core to sleep at the tick.
    a_sleep_entry: assert property (
        (s.mode == MODE_MEASURE && s.regs.powerCtl[MEASURE_BIT]
            && autoSleepOn && inactivityDetected && s.sampleStrobe)
        |=> sleepActive)
        else $error("autosleep did not enter sleep");

    // Rate only changes on a boundary.
    a_rate_boundary: assert property (
        (!boundary) |=> $stable(activeRate))
        else $error("rate changed between samples");

    // At a boundary low power follows the bit, and only while measuring.
    a_low_power: assert property (
        boundary |=> lowPowerActive == (s.mode == MODE_MEASURE
            && $past(s.regs.rateCtl[LOW_POWER_BIT])))
        else $error("low power active without request");

    // Buffer is never written outside measurement, nor on the edge after.
    a_buffer_hold: assert property (
        !measureActive |-> !bufferWrite ##1 !bufferWrite)
        else $error("buffer written in standby");

    // Sample strobes are never back to back and the timer stays in range.
    a_sample_period: assert property (
        sampleStrobe |=> (!sampleStrobe
            && s.sampleCount < periodCycles))
        else $error("sample period broken");

    // Standby with the measure bit clear stays in standby.
    a_standby_wait: assert property (
        (s.mode == MODE_STANDBY && !s.regs.powerCtl[MEASURE_BIT])
        |=> !measureActive)
        else $error("standby left without measure request");

    // A threshold write lands in the register on the next edge.
    a_thresh_write: assert property (
        (regWrite && regAddr == OFS_INACT_THRESH)
        |=> inactThreshold == $past(regWriteData))
        else $error("threshold write lost");

    // An inactivity time write lands in the register on the next edge.
    a_time_write: assert property (
        (regWrite && regAddr == OFS_INACT_TIME)
        |=> inactTime == $past(regWriteData))
        else $error("inactivity time write lost");

    // The status byte reports the mode and rate seen at the read edge.
    a_status_read: assert property (
        (regRead && regAddr == OFS_MODE_STATUS)
        |=> regReadData == {$past(activeRate), 1'b0, $past(lowPowerActive),
            $past(sleepActive), $past(measureActive)})
        else $error("status byte read back wrong");

    // Read data hold their value between reads.
    a_read_hold: assert property (
        !regRead |=> $stable(regReadData))
        else $error("read data changed without a read");

    // Standby applies the written rate code at every boundary.
    a_rate_follow: assert property (
        (boundary && s.mode == MODE_STANDBY)
        |=> activeRate == $past(s.regs.rateCtl[RATE_LSB +: 4]))
        else $error("rate code not applied in standby");

    // Mode only changes on a boundary.
    a_mode_boundary: assert property (
        (!boundary) |=> $stable(s.mode))
        else $error("mode changed between samples");

    // Without autosleep armed, measuring never falls asleep.
    a_no_sleep_unarmed: assert property (
        (s.mode == MODE_MEASURE && !autoSleepOn) |=> !sleepActive)
        else $error("sleep entered without autosleep");

    // Activity at a sample tick wakes the core back into measurement.
    a_sleep_wake: assert property (
        (s.mode == MODE_SLEEP && s.regs.powerCtl[MEASURE_BIT]
            && activityDetected && s.sampleStrobe)
        |=> (measureActive && !sleepActive))
        else $error("activity did not wake the core");

    // Standby holds the sample timer at zero.
    a_standby_timer: assert property (
        (s.mode == MODE_STANDBY) |=> s.sampleCount == 32'h0000_0000)
        else $error("sample timer ran in standby");

    // Low power is only ever in force while awake and measuring.
    a_low_power_mode: assert property (
        lowPowerActive |-> (measureActive && !sleepActive))
        else $error("low power outside measurement");

endmodule

`default_nettype wire

/* src/apr_pkg.sv */
// Package for the power-mode and output-rate controller.
// Assumes one 200 MHz clock and an 8-bit register port with 6-bit addresses.
`default_nettype none

package apr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [5:0] OFS_INACT_THRESH = 6'h25;
    localparam logic [5:0] OFS_INACT_TIME = 6'h26;
    localparam logic [5:0] OFS_RATE_CTL = 6'h2C;
    localparam logic [5:0] OFS_POWER_MODE_CONTROL = 6'h2D;
    localparam logic [5:0] OFS_MODE_STATUS = 6'h3F;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int RATE_LSB = 0;
    localparam int LOW_POWER_BIT = 4;
    localparam int MEASURE_BIT = 3;
    localparam int AUTOSLEEP_BIT = 4;
    localparam int LINK_BIT = 5;
    localparam int STAT_MEASURE_BIT = 0;
    localparam int STAT_SLEEP_BIT = 1;
    localparam int STAT_LOW_POWER_BIT = 2;
    localparam int STAT_RATE_LSB = 4;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [3:0] RATE_TOP = 4'hF;
    localparam logic [3:0] SLEEP_RATE = 4'h6;

    // ------------------------------------------------------------------
    // Timing: the fastest rate (3200 Hz) sets the base sample period
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int TOP_SAMPLE_PERIOD_NS = 312500;
    localparam int TOP_SAMPLE_CYCLES = TOP_SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

    // Operating modes of the sensor core.
    typedef enum logic [1:0] {
        MODE_STANDBY,
        MODE_MEASURE,
        MODE_SLEEP
    } apr_mode_type;

    // Software-visible control registers.
    typedef struct packed {
        logic [7:0] inactThresh;
        logic [7:0] inactTime;
        logic [7:0] rateCtl;
        logic [7:0] powerCtl;
    } apr_regs_type;

    // Whole state of the controller.
    typedef struct packed {
        apr_regs_type regs;
        apr_mode_type mode;
        logic [3:0] activeRate;
        logic activeLowPower;
        logic [31:0] sampleCount;
        logic sampleStrobe;
        logic [7:0] readData;
    } apr_state_type;

endpackage

`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the power-mode and output-rate controller.
// Assumes the controller drives its outputs from sys_clk rising edges.
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import apr_pkg::*;
;
    // ------------------------------------------------------------------
    // Clock, reset and stimulus signals
    // ------------------------------------------------------------------
    localparam int BASE = 4;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [7:0] regWriteData = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic inactivityDetected = 1'b0;
    logic activityDetected = 1'b0;
    logic [7:0] regReadData, inactThreshold, inactTime;
    logic measureActive, sleepActive, lowPowerActive;
    logic sampleStrobe, bufferWrite;
    logic [3:0] activeRate;
    int miscompares = 0;
    int comparisons = 0;

    // The sample base period is shortened so every rate fits the run.
    apr_power_rate_ctl #(.BASE_CYCLES(BASE)) u_apr_power_rate_ctl (
        .sys_clk(sys_clk), .nrst(nrst), .regAddr(regAddr),
        .regWriteData(regWriteData), .regWrite(regWrite),
        .regRead(regRead), .regReadData(regReadData),
        .inactivityDetected(inactivityDetected),
        .activityDetected(activityDetected),
        .inactThreshold(inactThreshold), .inactTime(inactTime),
        .measureActive(measureActive), .sleepActive(sleepActive),
        .lowPowerActive(lowPowerActive), .activeRate(activeRate),
        .sampleStrobe(sampleStrobe), .bufferWrite(bufferWrite));

    // The clock toggles every half period of 2.5 ns.
    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // Reporting and bus tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check_val(string what, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_count(string what, int exp, int got);
        comparisons++;
        if (got != exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // One write cycle; strobe drops at the edge that takes it.
    task automatic reg_write(logic [5:0] addr, logic [7:0] data);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= addr;
        regWriteData <= data;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    // One read cycle; data is sampled in the cycle after the strobe.
    task automatic reg_read(logic [5:0] addr, logic [7:0] exp, string what);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        check_val(what, exp, regReadData);
    endtask

    // Waits for a sample strobe, giving up after a bounded count.
    task automatic wait_strobe(int limit, output int n);
        n = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        while (sampleStrobe !== 1'b1 && n < limit);
        check_val("sample strobe", 8'h01, {7'h00, sampleStrobe});
        if (sampleStrobe !== 1'b1)
            end_of_test();
    endtask

    // Measures the strobe spacing and the buffer write beside it.
    task automatic check_period(int exp);
        int n;
        wait_strobe(exp + 8, n);
        check_val("buffer write", 8'h01, {7'h00, bufferWrite});
        wait_strobe(exp + 8, n);
        check_count("sample period", exp, n);
    endtask

    // Waits for sleep or measure level to reach a value within a bound.
    task automatic wait_flag(bit sleep, logic want, int limit);
        int n;
        n = 0;
        #1;
        while ((sleep ? sleepActive : measureActive) !== want && n < limit)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        check_val("mode flag", {7'h00, want},
            {7'h00, sleep ? sleepActive : measureActive});
        if ((sleep ? sleepActive : measureActive) !== want)
            end_of_test();
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Power-up state and register reset values.
    task automatic t_reset();
        check_val("measure at reset", 8'h00, {7'h00, measureActive});
        check_val("strobe at reset", 8'h00, {7'h00, sampleStrobe});
        reg_read(OFS_INACT_THRESH, 8'h00, "threshold reset");
        reg_read(OFS_RATE_CTL, 8'h00, "rate reset");
        reg_read(OFS_POWER_MODE_CONTROL, 8'h00, "power reset");
        reg_read(6'h10, 8'h00, "unmapped read");
    endtask

    // Every register except the rate control written and read back while in standby.
    task automatic t_regs();
        reg_write(OFS_INACT_THRESH, 8'hA5);
        reg_write(OFS_INACT_TIME, 8'h3C);
        reg_write(OFS_POWER_MODE_CONTROL, 8'h30);
        reg_write(6'h10, 8'hFF);
        reg_read(OFS_INACT_THRESH, 8'hA5, "threshold");
        reg_read(OFS_INACT_TIME, 8'h3C, "inactivity time");
        reg_read(OFS_POWER_MODE_CONTROL, 8'h30, "power control");
        reg_read(6'h10, 8'h00, "unmapped after write");
        check_val("threshold out", 8'hA5, inactThreshold);
        check_val("time out", 8'h3C, inactTime);
        check_val("still standby", 8'h00, {7'h00, measureActive});
        reg_write(OFS_POWER_MODE_CONTROL, 8'h00);
    endtask

    // Low power at rate 1100, entered from standby.
    task automatic t_low_power();
        reg_write(OFS_RATE_CTL, 8'h1C);
        reg_write(OFS_POWER_MODE_CONTROL, 8'h08);
        @(posedge sys_clk);
        #1;
        check_val("measure on", 8'h01, {7'h00, measureActive});
        check_val("low power", 8'h01, {7'h00, lowPowerActive});
        check_val("rate", 8'h0C, {4'h0, activeRate});
        check_period(BASE << 3);
        reg_read(OFS_MODE_STATUS, 8'hC5, "status");
    endtask

    // Clearing measure stops sampling and buffer writes.
    task automatic t_standby();
        int k;
        reg_write(OFS_POWER_MODE_CONTROL, 8'h00);
        wait_flag(1'b0, 1'b0, (BASE << 3) + 4);
        for (k = 0; k < 80; k++)
        begin
            @(posedge sys_clk);
            #1;
            check_val("standby strobe", 8'h00,
                {6'h00, sampleStrobe, bufferWrite});
        end
    endtask

    // Fastest rate, then a rate change applied in measurement.
    task automatic t_rate_change();
        reg_write(OFS_RATE_CTL, 8'h0F);
        reg_write(OFS_POWER_MODE_CONTROL, 8'h08);
        check_period(BASE);
        reg_write(OFS_RATE_CTL, 8'h0E);
        check_period(BASE << 1);
        check_val("new rate", 8'h0E, {4'h0, activeRate});
        check_val("no low power", 8'h00, {7'h00, lowPowerActive});
    endtask

    // Autosleep on inactivity, then wake on activity.
    task automatic t_autosleep();
        reg_write(OFS_INACT_THRESH, 8'h10);
        reg_write(OFS_INACT_TIME, 8'h05);
        reg_write(OFS_POWER_MODE_CONTROL, 8'h38);
        @(posedge sys_clk);
        inactivityDetected <= 1'b1;
        wait_flag(1'b1, 1'b1, 40);
        check_val("sleep rate", 8'h06, {4'h0, activeRate});
        check_period(BASE << 9);
        @(posedge sys_clk);
        inactivityDetected <= 1'b0;
        activityDetected <= 1'b1;
        wait_flag(1'b1, 1'b0, (BASE << 9) + 8);
        check_val("awake rate", 8'h0E, {4'h0, activeRate});
        check_val("still measuring", 8'h01, {7'h00, measureActive});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        t_regs();
        t_low_power();
        t_standby();
        t_rate_change();
        t_autosleep();
        // A reset while measuring must fall back to the power-up state.
        @(posedge sys_clk);
        nrst <= 1'b0;
        #1;
        t_reset();
        @(posedge sys_clk);
        nrst <= 1'b1;
        #1;
        t_reset();
        end_of_test();
    end
endmodule

`default_nettype wire
